// >>> design/rrc_regs.svh
/*
  Constants for the return and rotate-through-carry execution block:
  register offsets, field positions, reset values, opcode patterns, sizes.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef RRC_REGS_SVH
`define RRC_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define RRC_OFS_CTRL      8'h00
`define RRC_OFS_WREG      8'h04
`define RRC_OFS_FLAGS     8'h08
`define RRC_OFS_BANK      8'h0C
`define RRC_OFS_WSHAD     8'h10
`define RRC_OFS_FSHAD     8'h14
`define RRC_OFS_BSHAD     8'h18
`define RRC_OFS_PC        8'h1C
`define RRC_OFS_PCU       8'h20
`define RRC_OFS_PCH       8'h24
`define RRC_OFS_IDXBASE   8'h28
`define RRC_OFS_STACK     8'h2C
`define RRC_OFS_EXSTAT    8'h30

// ==========================================================================
// Field positions
`define RRC_CTRL_EXT_BIT  0
`define RRC_FLAG_C_BIT    0
`define RRC_FLAG_Z_BIT    2
`define RRC_FLAG_N_BIT    4

// ==========================================================================
// Reset values
`define RRC_RST_BYTE      8'h00
`define RRC_RST_PC        21'h00_0000
`define RRC_RST_IDX       12'h000

// ==========================================================================
// Opcode patterns
`define RRC_RET_PATTERN   15'h0009
`define RRC_ROT_PATTERN   6'h0D
`define RRC_ACCESS_LIMIT  8'h5F
`define RRC_ACCESS_HIBANK 4'hF

// ==========================================================================
// Sizes
`define RRC_STACK_DEPTH   31
`define RRC_PC_WIDTH      21

`endif

// >>> design/rrc_pkg.sv
/*
  Types shared by the execution block, its checker and its bench.
  Assumes the constants header is available by bare name.
*/
`include "rrc_regs.svh"

package rrc_pkg;

  // ========================================================================
  // Execution states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Waiting for an instruction at Q1
    ST_ROT  = 2'b01,  // Rotate in progress, Q2..Q4
    ST_RET  = 2'b10,  // Return, first instruction cycle
    ST_DEAD = 2'b11   // Return, second (empty) instruction cycle
  } rrc_state_e;

  // ========================================================================
  // File register access port toward the data memory
  typedef struct packed {
    logic [11:0] addr;    // Full data memory address
    logic        rdEn;    // Read request, one cycle
    logic        wrEn;    // Write request, one cycle
    logic [7:0]  wrData;  // Write data
  } rrc_file_port_s;

  // ========================================================================
  // Status flags touched by the rotate
  typedef struct packed {
    logic n;  // Negative
    logic z;  // Zero
    logic c;  // Carry
  } rrc_flags_s;

endpackage

// >>> design/rrc_qphase.sv
/*
  Four-phase instruction cycle divider.
  Assumes one free-running core clock and an asynchronous high reset.
*/
module rrc_qphase (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic      [1:0] phase,
  output logic            cycleStart
);

  // ========================================================================
  // Phase counter: 0=Q1, 1=Q2, 2=Q3, 3=Q4; wraps naturally
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Pulse in the Q1 clock of every instruction cycle
  assign cycleStart = (phase == 2'h0);

endmodule

// >>> design/rrc_ret_stack.sv
/*
  Hardware return stack held in flip-flops.
  Assumes push and pop never arrive in the same cycle from one owner;
  if they do, pop wins and push is dropped.
*/
`include "rrc_regs.svh"

module rrc_ret_stack (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        push,
  input  wire logic [`RRC_PC_WIDTH-1:0]    pushData,
  input  wire logic                        pop,
  output logic      [`RRC_PC_WIDTH-1:0]    top,
  output logic      [4:0]                  depth
);

  // ========================================================================
  // Storage and pointer
  logic [`RRC_PC_WIDTH-1:0] mem [`RRC_STACK_DEPTH];  // Entries, index 0 first
  wire  full  = (depth == 5'(`RRC_STACK_DEPTH));     // Further pushes dropped
  wire  empty = (depth == 5'h00);                   // Pop of empty yields zero
  wire  doPop  = pop && !empty;
  wire  doPush = push && !pop && !full;

  // Top entry; an empty stack shows zero so the PC lands at the reset vector
  assign top = empty ? `RRC_RST_PC : mem[depth - 5'h01];

  // ========================================================================
  // Pointer update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      depth <= 5'h00;
    end else if (doPop) begin
      depth <= depth - 5'h01;
    end else if (doPush) begin
      depth <= depth + 5'h01;
    end
  end

  // Entry write, no reset needed on data
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[depth] <= pushData;
    end
  end

endmodule

// >>> design/rrc_exec.sv
/*
  Execution logic for the subroutine return and the rotate left through
  carry. Holds the working, shadow, bank and PC registers, exposed on a
  plain register port. Assumes instructions come from same-clock logic,
  and the data memory answers a read one clock after the request.
*/
`include "rrc_regs.svh"

module rrc_exec (
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [7:0]               regAddr,
  input  wire logic [31:0]              regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [31:0]              regRdData,
  // Instruction supply
  input  wire logic [15:0]              instr,
  input  wire logic                     instrValid,
  output logic                          instrReady,
  // Data memory
  output rrc_pkg::rrc_file_port_s       filePort,
  input  wire logic [7:0]               fileRdData,
  // Program counter view
  output logic [`RRC_PC_WIDTH-1:0]      pc
);

  // ==========================================================================
  // Architectural registers
  logic [7:0]                wReg;       // Working accumulator
  logic [7:0]                flagsReg;   // Status flags
  logic [7:0]                bankReg;    // Bank select
  logic [7:0]                wShadow;    // Shadow accumulator
  logic [7:0]                fShadow;    // Shadow status
  logic [7:0]                bShadow;    // Shadow bank select
  logic [7:0]                pcuLatch;   // PC upper latch
  logic [7:0]                pchLatch;   // PC high latch
  logic [11:0]               idxBase;    // Base for indexed literal offset
  logic                      extEnable;  // Extended instruction set on
  logic [15:0]               curInstr;   // Instruction being executed
  logic [7:0]                fileVal;    // Operand captured at Q3
  rrc_pkg::rrc_state_e       state;      // Execution state
  rrc_pkg::rrc_state_e       next_state; // Next execution state

  // ==========================================================================
  // Helpers
  // Operand address from the access bit, the bank and the mode
  function automatic logic [11:0] fileAddress(input logic [7:0] f, input logic a,
                                               input logic [7:0] bank, input logic ext,
                                               input logic [11:0] base);
    logic low;
    low = (f <= `RRC_ACCESS_LIMIT);
    if (a) begin
      fileAddress = {bank[3:0], f};
    end else if (ext && low) begin
      fileAddress = 12'(base + {4'h0, f});
    end else if (low) begin
      fileAddress = {4'h0, f};
    end else begin
      fileAddress = {`RRC_ACCESS_HIBANK, f};
    end
  endfunction

  // Rotate left through carry: {carry out, result}
  function automatic logic [8:0] rotLeft(input logic [7:0] v, input logic cin);
    rotLeft = {v[7], v[6:0], cin};
  endfunction

  // ==========================================================================
  // Phase divider and return stack
  logic [1:0]                phase;      // Q phase, 0 is Q1
  logic                      cycleStart; // Q1 pulse
  logic [`RRC_PC_WIDTH-1:0]  stackTop;   // Current top entry
  logic [4:0]                stackDepth; // Entries in use

  rrc_qphase uPhase (
    .clk        (clk),
    .rst        (rst),
    .phase      (phase),
    .cycleStart (cycleStart)
  );

  // Decode of the incoming word
  wire isRet = (instr[15:1] == `RRC_RET_PATTERN);
  wire isRot = (instr[15:10] == `RRC_ROT_PATTERN);
  wire accept = instrReady && instrValid;

  // Phase strobes
  wire inQ2 = (phase == 2'h1);
  wire inQ3 = (phase == 2'h2);
  wire inQ4 = (phase == 2'h3);

  // Return actions: pop at Q4 of the first cycle
  wire retPop     = (state == rrc_pkg::ST_RET) && inQ4;
  wire retRestore = retPop && curInstr[0];

  // Rotate operands and result
  wire       curD     = curInstr[9];
  wire       curA     = curInstr[8];
  wire [11:0] opAddr  = fileAddress(curInstr[7:0], curA, bankReg, extEnable, idxBase);
  wire [8:0] rotOut   = rotLeft(fileVal, flagsReg[`RRC_FLAG_C_BIT]);
  wire       rotWrite = (state == rrc_pkg::ST_ROT) && inQ4;
  rrc_pkg::rrc_flags_s rotFlags;
  assign rotFlags.c = rotOut[8];
  assign rotFlags.z = (rotOut[7:0] == 8'h00);
  assign rotFlags.n = rotOut[7];

  // Bus write decodes
  wire wrCtrl  = regWr && (regAddr == `RRC_OFS_CTRL);
  wire wrW     = regWr && (regAddr == `RRC_OFS_WREG);
  wire wrFlags = regWr && (regAddr == `RRC_OFS_FLAGS);
  wire wrBank  = regWr && (regAddr == `RRC_OFS_BANK);
  wire wrWS    = regWr && (regAddr == `RRC_OFS_WSHAD);
  wire wrFS    = regWr && (regAddr == `RRC_OFS_FSHAD);
  wire wrBS    = regWr && (regAddr == `RRC_OFS_BSHAD);
  wire wrPc    = regWr && (regAddr == `RRC_OFS_PC);
  wire wrPcu   = regWr && (regAddr == `RRC_OFS_PCU);
  wire wrPch   = regWr && (regAddr == `RRC_OFS_PCH);
  wire wrIdx   = regWr && (regAddr == `RRC_OFS_IDXBASE);
  wire wrStack = regWr && (regAddr == `RRC_OFS_STACK);

  rrc_ret_stack uStack (
    .clk      (clk),
    .rst      (rst),
    .push     (wrStack),
    .pushData (regWrData[`RRC_PC_WIDTH-1:0]),
    .pop      (retPop),
    .top      (stackTop),
    .depth    (stackDepth)
  );

  // ==========================================================================
  // Sequencer
  // Only accept at Q1 while idle, so each instruction owns whole cycles
  assign instrReady = cycleStart && (state == rrc_pkg::ST_IDLE);

  // Next state; unknown opcodes are consumed as one empty cycle
  always_comb begin
    next_state = state;
    case (state)
      rrc_pkg::ST_IDLE: begin
        if (accept && isRet) begin
          next_state = rrc_pkg::ST_RET;
        end else if (accept && isRot) begin
          next_state = rrc_pkg::ST_ROT;
        end
      end
      rrc_pkg::ST_ROT: begin
        if (inQ4) begin
          next_state = rrc_pkg::ST_IDLE;
        end
      end
      rrc_pkg::ST_RET: begin
        if (inQ4) begin
          next_state = rrc_pkg::ST_DEAD;
        end
      end
      rrc_pkg::ST_DEAD: begin
        if (inQ4) begin
          next_state = rrc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = rrc_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= rrc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Instruction latch at acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      curInstr <= 16'h0000;
    end else if (accept) begin
      curInstr <= instr;
    end
  end

  // Operand capture at Q3, one clock after the Q2 read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fileVal <= `RRC_RST_BYTE;
    end else if ((state == rrc_pkg::ST_ROT) && inQ3) begin
      fileVal <= fileRdData;
    end
  end

  // ==========================================================================
  // Data memory port, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filePort <= '0;
    end else begin
      filePort.rdEn   <= (next_state == rrc_pkg::ST_ROT) && (state == rrc_pkg::ST_IDLE);
      filePort.wrEn   <= 1'b0;
      filePort.wrData <= rotOut[7:0];
      if (accept && isRot) begin
        // Address of the operand, presented during Q2
        filePort.addr <= fileAddress(instr[7:0], instr[8], bankReg, extEnable, idxBase);
      end else begin
        filePort.addr <= opAddr;
      end
      if (rotWrite && curD) begin
        filePort.wrEn <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Working registers; core updates take priority over bus writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wReg <= `RRC_RST_BYTE;
    end else if (retRestore) begin
      wReg <= wShadow;
    end else if (rotWrite && !curD) begin
      wReg <= rotOut[7:0];
    end else if (wrW) begin
      wReg <= regWrData[7:0];
    end
  end

  // Flags: return without restore leaves them alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flagsReg <= `RRC_RST_BYTE;
    end else if (retRestore) begin
      flagsReg <= fShadow;
    end else if (rotWrite) begin
      flagsReg[`RRC_FLAG_C_BIT] <= rotFlags.c;
      flagsReg[`RRC_FLAG_Z_BIT] <= rotFlags.z;
      flagsReg[`RRC_FLAG_N_BIT] <= rotFlags.n;
    end else if (wrFlags) begin
      flagsReg <= regWrData[7:0];
    end
  end

  // Bank select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bankReg <= `RRC_RST_BYTE;
    end else if (retRestore) begin
      bankReg <= bShadow;
    end else if (wrBank) begin
      bankReg <= regWrData[7:0];
    end
  end

  // Program counter: loaded only from the stack top or the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= `RRC_RST_PC;
    end else if (retPop) begin
      pc <= stackTop;
    end else if (wrPc) begin
      pc <= regWrData[`RRC_PC_WIDTH-1:0];
    end
  end

  // Shadows, latches, base and control: bus only; return never
  // touches the PC latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wShadow   <= `RRC_RST_BYTE;
      fShadow   <= `RRC_RST_BYTE;
      bShadow   <= `RRC_RST_BYTE;
      pcuLatch  <= `RRC_RST_BYTE;
      pchLatch  <= `RRC_RST_BYTE;
      idxBase   <= `RRC_RST_IDX;
      extEnable <= 1'b0;
    end else begin
      if (wrWS)   wShadow  <= regWrData[7:0];
      if (wrFS)   fShadow  <= regWrData[7:0];
      if (wrBS)   bShadow  <= regWrData[7:0];
      if (wrPcu)  pcuLatch <= regWrData[7:0];
      if (wrPch)  pchLatch <= regWrData[7:0];
      if (wrIdx)  idxBase  <= regWrData[11:0];
      if (wrCtrl) extEnable <= regWrData[`RRC_CTRL_EXT_BIT];
    end
  end

  // ==========================================================================
  // Read path: data stands the cycle after the strobe; unmapped reads zero
  logic [31:0] rdMux;  // Selected read value
  always_comb begin
    case (regAddr)
      `RRC_OFS_CTRL:    rdMux = {31'h0000_0000, extEnable};
      `RRC_OFS_WREG:    rdMux = {24'h00_0000, wReg};
      `RRC_OFS_FLAGS:   rdMux = {24'h00_0000, flagsReg};
      `RRC_OFS_BANK:    rdMux = {24'h00_0000, bankReg};
      `RRC_OFS_WSHAD:   rdMux = {24'h00_0000, wShadow};
      `RRC_OFS_FSHAD:   rdMux = {24'h00_0000, fShadow};
      `RRC_OFS_BSHAD:   rdMux = {24'h00_0000, bShadow};
      `RRC_OFS_PC:      rdMux = {11'h000, pc};
      `RRC_OFS_PCU:     rdMux = {24'h00_0000, pcuLatch};
      `RRC_OFS_PCH:     rdMux = {24'h00_0000, pchLatch};
      `RRC_OFS_IDXBASE: rdMux = {20'h0_0000, idxBase};
      `RRC_OFS_STACK:   rdMux = {11'h000, stackTop};
      `RRC_OFS_EXSTAT:  rdMux = {25'h000_0000, stackDepth, state};
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  // Read data register, cleared when no read so it stands one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule

// >>> dv/rrc_exec_sva.sv
/*
  Port checker for the return and rotate-through-carry execution block.
  Assumes the package and the constants header are compiled before it.
*/
`include "rrc_regs.svh"

module rrc_exec_sva (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [7:0]                   regAddr,
  input wire logic [31:0]                  regWrData,
  input wire logic                         regWr,
  input wire logic                         regRd,
  input wire logic [31:0]                  regRdData,
  input wire logic [15:0]                  instr,
  input wire logic                         instrValid,
  input wire logic                         instrReady,
  input wire rrc_pkg::rrc_file_port_s      filePort,
  input wire logic [7:0]                   fileRdData,
  input wire logic [`RRC_PC_WIDTH-1:0]     pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Decode of the word taken this clock
  wire       acc   = instrReady && instrValid;               // Word accepted
  wire       isRet = instr[15:1] == `RRC_RET_PATTERN;        // Return form
  wire       isRot = instr[15:10] == `RRC_ROT_PATTERN;       // Rotate form
  logic [7:0] lastF;                                         // Held file address
  logic       lastA;                                         // Held access bit

  // Operand kept so the memory checks need no fixed latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastF <= 8'h00;
      lastA <= 1'b0;
    end else if (acc) begin
      lastF <= instr[7:0];
      lastA <= instr[8];
    end
  end

  // ========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_ret_ready;
    acc && isRet |=> !instrReady [*7] ##1 instrReady;
  endproperty
  a_ret_ready: assert property (p_ret_ready) else $error("return length wrong");
  property p_ret_pc;
    acc && isRet |=> $stable(pc) [*2] ##3 $stable(pc) [*3];
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("pc moved off its slot");
  property p_ret_no_mem;
    acc && isRet |=> (!filePort.rdEn && !filePort.wrEn) [*8];
  endproperty
  a_ret_no_mem: assert property (p_ret_no_mem) else $error("return touched memory");
  property p_rot_read;
    acc && isRot |-> ##[1:2] filePort.rdEn;
  endproperty
  a_rot_read: assert property (p_rot_read) else $error("rotate read missing");
  property p_rot_write;
    acc && isRot && instr[9] |-> ##[3:5] filePort.wrEn;
  endproperty
  a_rot_write: assert property (p_rot_write) else $error("rotate write missing");
  property p_rot_keep;
    acc && isRot && !instr[9] |=> !filePort.wrEn [*6];
  endproperty
  a_rot_keep: assert property (p_rot_keep) else $error("write with d clear");
  property p_banked;
    filePort.rdEn && lastA |-> filePort.addr[7:0] == lastF;
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");
  property p_hibank;
    filePort.rdEn && !lastA && lastF > `RRC_ACCESS_LIMIT
      |-> filePort.addr == {`RRC_ACCESS_HIBANK, lastF};
  endproperty
  a_hibank: assert property (p_hibank) else $error("access bank address wrong");
  property p_q1;
    instrReady |=> !instrReady [*3];
  endproperty
  a_q1: assert property (p_q1) else $error("ready outside Q1");
endmodule

bind rrc_exec rrc_exec_sva u_sva (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .instr(instr), .instrValid(instrValid),
  .instrReady(instrReady), .filePort(filePort), .fileRdData(fileRdData), .pc(pc)
);

// >>> dv/rrc_exec_tb_top.sv
/*
  Self-checking bench: register port tasks, an instruction driver and a
  data memory stand-in. Assumes design, package and checker come first.
*/
`include "rrc_regs.svh"

module rrc_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Stimulus and observation
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic [7:0]                regAddr = 8'h00;
  logic [31:0]               regWrData = 32'h0000_0000;
  logic                      regWr = 1'b0;
  logic                      regRd = 1'b0;
  logic [31:0]               regRdData;
  logic [15:0]               instr = 16'h0000;
  logic                      instrValid = 1'b0;
  logic                      instrReady;
  rrc_pkg::rrc_file_port_s   filePort;
  logic [7:0]                fileRdData;
  logic [`RRC_PC_WIDTH-1:0]  pc;
  logic [7:0]                memData = 8'h00;  // Byte the memory returns
  logic                      rdSeen = 1'b0;    // Read was asked last clock
  logic [11:0]               rdAddr = 12'h000; // Address of last read
  logic [7:0]                wrVal = 8'h00;    // Byte of last write
  int                        wrCount = 0;      // Memory writes seen so far
  int                        failures = 0;
  int                        samplesChecked = 0;
  int                        cycles = 0;

  always #5 clk = ~clk;

  rrc_exec DUT (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .instr(instr), .instrValid(instrValid),
    .instrReady(instrReady), .filePort(filePort), .fileRdData(fileRdData), .pc(pc)
  );

  // ========================================================================
  // Memory stand-in: data valid from the request through the next clock,
  // inverted otherwise so a late capture cannot pass by luck
  assign fileRdData = (filePort.rdEn || rdSeen) ? memData : ~memData;

  always @(posedge clk) begin
    rdSeen <= filePort.rdEn;
    if (filePort.rdEn) begin
      rdAddr <= filePort.addr;
    end
    if (filePort.wrEn) begin
      wrVal  <= filePort.wrData;
      wrCount <= wrCount + 1;
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run;
    end
  end

  // ========================================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask

  // Hold the word until taken, then let the longest form finish
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk);
    instr      <= w;
    instrValid <= 1'b1;
    // Ready is looked at mid-cycle where it has settled; the next edge takes the word
    do begin
      @(negedge clk);
      n++;
    end while (instrReady !== 1'b1 && n < 8);
    check({31'h0, instrReady}, 32'h1);
    @(posedge clk);
    instrValid <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic rot(input logic [15:0] w, input logic [7:0] mem, input logic cin,
                     input logic [3:0] bank, input logic ext, input logic [11:0] expAddr,
                     input logic [7:0] res, input logic [7:0] flg);
    int w0;  // Write count before the rotate
    reg_wr(`RRC_OFS_CTRL, {31'h0, ext});
    reg_wr(`RRC_OFS_BANK, {28'h0, bank});
    reg_wr(`RRC_OFS_FLAGS, {31'h0, cin});
    reg_wr(`RRC_OFS_IDXBASE, 32'h0000_0100);
    reg_wr(`RRC_OFS_WREG, 32'h0000_005A);
    memData <= mem;
    w0 = wrCount;
    exec(w);
    check({20'h0, rdAddr}, {20'h0, expAddr});
    check(wrCount - w0, {31'h0, w[9]});
    if (w[9]) begin
      check({24'h0, wrVal}, {24'h0, res});
      reg_rd(`RRC_OFS_WREG, 32'h0000_005A);
    end else begin
      reg_rd(`RRC_OFS_WREG, {24'h0, res});
    end
    reg_rd(`RRC_OFS_FLAGS, {24'h0, flg});
  endtask

  task automatic complete_run;
    $display("checks=%0d failures=%0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    logic [15:0] bad [3];
    bad = '{16'h0011, 16'h0014, 16'h0000};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    reg_rd(`RRC_OFS_WREG, 32'h0);
    reg_rd(`RRC_OFS_PC, 32'h0);
    reg_wr(8'hFC, 32'hFFFF_FFFF);
    reg_rd(8'hFC, 32'h0);
    // Rotates: access bank high, banked, indexed, both edges of the limit
    rot(16'h3480, 8'hE6, 1'b0, 4'h0, 1'b0, 12'hF80, 8'hCC, 8'h11);
    rot(16'h3712, 8'h80, 1'b0, 4'h3, 1'b0, 12'h312, 8'h00, 8'h05);
    rot(16'h3420, 8'h41, 1'b1, 4'h0, 1'b1, 12'h120, 8'h83, 8'h10);
    rot(16'h365F, 8'h7F, 1'b0, 4'h0, 1'b0, 12'h05F, 8'hFE, 8'h10);
    rot(16'h3460, 8'h01, 1'b0, 4'h0, 1'b1, 12'hF60, 8'h02, 8'h00);
    // Return with restore, then without
    reg_wr(`RRC_OFS_STACK, 32'h0000_0ABC);
    reg_wr(`RRC_OFS_STACK, 32'h000A_1B2C);
    reg_wr(`RRC_OFS_STACK, 32'h001F_0F0E);
    reg_wr(`RRC_OFS_WREG, 32'h0000_0011);
    reg_wr(`RRC_OFS_FLAGS, 32'h0000_0001);
    reg_wr(`RRC_OFS_BANK, 32'h0000_0002);
    reg_wr(`RRC_OFS_WSHAD, 32'h0000_0022);
    reg_wr(`RRC_OFS_FSHAD, 32'h0000_0014);
    reg_wr(`RRC_OFS_BSHAD, 32'h0000_0005);
    reg_wr(`RRC_OFS_PCU, 32'h0000_0007);
    reg_wr(`RRC_OFS_PCH, 32'h0000_0033);
    exec(16'h0013);
    check({11'h0, pc}, 32'h001F_0F0E);
    reg_rd(`RRC_OFS_WREG, 32'h0000_0022);
    reg_rd(`RRC_OFS_FLAGS, 32'h0000_0014);
    reg_rd(`RRC_OFS_BANK, 32'h0000_0005);
    reg_rd(`RRC_OFS_PCU, 32'h0000_0007);
    reg_rd(`RRC_OFS_PCH, 32'h0000_0033);
    reg_wr(`RRC_OFS_WREG, 32'h0000_0066);
    exec(16'h0012);
    check({11'h0, pc}, 32'h000A_1B2C);
    reg_rd(`RRC_OFS_WREG, 32'h0000_0066);
    reg_rd(`RRC_OFS_FLAGS, 32'h0000_0014);
    reg_rd(`RRC_OFS_BANK, 32'h0000_0005);
    // Near misses of the return pattern must not pop
    for (int i = 0; i < 3; i++) begin
      exec(bad[i]);
      check({11'h0, pc}, 32'h000A_1B2C);
    end
    reg_rd(`RRC_OFS_STACK, 32'h0000_0ABC);
    complete_run;
  end
endmodule
